/* core/tx_timing_pkg.sv */
// constants for the per-channel transmit timing source and line control block
package tx_timing_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned ACLK_MHZ          = 125;
  localparam int unsigned BASE_RATE_KHZ     = 1544;
  // internal timing divider: rounded down so the tick is never slower than base rate
  localparam int unsigned INT_DIV_CYCLES    = (ACLK_MHZ * 1000) / BASE_RATE_KHZ;
  localparam int unsigned FRAME_BITS        = 193;
  localparam int unsigned MULTIFRAME_FRAMES = 24;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int unsigned CHANNELS           = 4;
  localparam int unsigned ADDR_W             = 18;
  localparam logic [11:0] IDX_CLOCK_SELECT   = 12'h100;
  localparam logic [11:0] IDX_LINE_IF_CTRL   = 12'h101;
  localparam logic [11:0] IDX_SYNC_MUX       = 12'h109;
  localparam logic [11:0] IDX_BACKPLANE_CFG  = 12'h1F0;
  localparam logic [11:0] IDX_CHAN_STATUS    = 12'h1F1;
  localparam logic [15:0] IDX_LIU_GLOBAL0    = 16'h0FE0;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  CLOCK_SELECT_RESET = 8'h01;
  localparam logic [7:0]  CLOCK_SELECT_MASK  = 8'h0F;
  localparam logic [7:0]  LINE_IF_RESET      = 8'h00;
  localparam logic [7:0]  SYNC_MUX_RESET     = 8'h00;
  localparam logic [7:0]  SYNC_MUX_MASK      = 8'h10;
  localparam logic [7:0]  BACKPLANE_RESET    = 8'h00;
  localparam logic [7:0]  LIU_GLOBAL_RESET   = 8'h00;
  localparam logic [7:0]  LIU_GLOBAL_MASK    = 8'h80;
  localparam int unsigned CSS_LSB            = 0;
  localparam int unsigned FORCE_LOSS_PATTERN_BIT      = 7;
  localparam int unsigned RAIL_MODE_BIT      = 6;
  localparam int unsigned LOOPBACK_LSB       = 4;
  localparam int unsigned SYNC_INVERT_BIT    = 4;
  localparam int unsigned HIGH_SPEED_BIT     = 0;
  localparam int unsigned GLOBAL_SR_BIT      = 7;
  localparam int unsigned STAT_OVERRUN_BIT   = 0;

  localparam logic [1:0]  RESP_OKAY          = 2'h0;
  localparam logic [1:0]  RESP_SLVERR        = 2'h2;

  typedef enum logic [1:0] {
    CSS_LOOP_A   = 2'h0,
    CSS_EXTERNAL = 2'h1,
    CSS_INTERNAL = 2'h2,
    CSS_LOOP_B   = 2'h3
  } timing_source_type;

  typedef enum logic [1:0] {
    LB_NORMAL  = 2'h0,
    LB_LOCAL   = 2'h1,
    LB_REMOTE  = 2'h2,
    LB_PAYLOAD = 2'h3
  } loopback_type;

endpackage : tx_timing_pkg

/* core/pair_buffer.sv */
// two-entry valid/ready buffer with registered outputs
`timescale 1ns/10ps
`default_nettype none
module pair_buffer #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] head_q, head_d, tail_q, tail_d;
  logic             head_v_q, head_v_d, tail_v_q, tail_v_d;

  assign out_valid = head_v_q;
  assign out_data  = head_q;
  assign in_ready  = ~tail_v_q;

  always_comb begin
    head_d   = head_q;
    head_v_d = head_v_q;
    tail_d   = tail_q;
    tail_v_d = tail_v_q;
    if (head_v_q && out_ready) begin
      head_v_d = tail_v_q;
      head_d   = tail_q;
      tail_v_d = 1'b0;
    end
    if (in_valid && ~tail_v_q) begin
      if (!head_v_d) begin
        head_d   = in_data;
        head_v_d = 1'b1;
      end else begin
        tail_d   = in_data;
        tail_v_d = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      head_q   <= '0;
      tail_q   <= '0;
      head_v_q <= 1'b0;
      tail_v_q <= 1'b0;
    end else begin
      head_q   <= head_d;
      tail_q   <= tail_d;
      head_v_q <= head_v_d;
      tail_v_q <= tail_v_d;
    end
  end

endmodule : pair_buffer
`default_nettype wire

/* core/tx_timing_source_line_control.sv */
// per-channel transmit timing source, pin direction, loopback and line control
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module tx_timing_source_line_control #(
  parameter int unsigned NCH     = tx_timing_pkg::CHANNELS,
  parameter int unsigned INT_DIV = tx_timing_pkg::INT_DIV_CYCLES
) (
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  input  wire logic [tx_timing_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                            awvalid,
  output logic                                 awready,
  input  wire logic [31:0]                     wdata,
  input  wire logic [3:0]                      wstrb,
  input  wire logic                            wvalid,
  output logic                                 wready,
  output logic [1:0]                           bresp,
  output logic                                 bvalid,
  input  wire logic                            bready,
  input  wire logic [tx_timing_pkg::ADDR_W-1:0] araddr,
  input  wire logic                            arvalid,
  output logic                                 arready,
  output logic [31:0]                          rdata,
  output logic [1:0]                           rresp,
  output logic                                 rvalid,
  input  wire logic                            rready,
  input  wire logic [NCH-1:0]                  recovered_line_clock,
  input  wire logic [NCH-1:0]                  tx_serial_clock_pin_i,
  output logic      [NCH-1:0]                  tx_serial_clock_pin_o,
  output logic      [NCH-1:0]                  tx_serial_clock_pin_oe,
  output logic      [NCH-1:0]                  tx_frame_sync_pin_o,
  output logic      [NCH-1:0]                  tx_frame_sync_pin_oe,
  output logic      [NCH-1:0]                  tx_multiframe_sync_pin_o,
  output logic      [NCH-1:0]                  tx_multiframe_sync_pin_oe,
  input  wire logic [NCH-1:0]                  tx_backplane_data,
  input  wire logic [NCH-1:0]                  rx_line_data,
  output logic      [NCH-1:0]                  rx_backplane_data,
  output logic      [NCH-1:0]                  line_tx_valid,
  input  wire logic [NCH-1:0]                  line_tx_ready,
  output logic      [NCH-1:0]                  line_tx_data
);
  import tx_timing_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers: recovered clock, serial clock, tx data, rx data
  // ----------------------------------------------------------------
  localparam int unsigned SW = 4 * NCH;
  logic [SW-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d, rise;
  logic [NCH-1:0] rec_lvl, rec_rise, ser_rise, txd_lvl, rxd_lvl;

  always_comb begin
    // a change is accepted once the second and third stages agree
    lvl_d = (s2_q ~^ s3_q) & s3_q | ~(s2_q ~^ s3_q) & lvl_q;
    rise  = lvl_d & ~lvl_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      lvl_q <= '0;
    end else begin
      s1_q  <= {rx_line_data, tx_backplane_data, tx_serial_clock_pin_i, recovered_line_clock};
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign rec_lvl  = lvl_q[NCH-1:0];
  assign rec_rise = rise[NCH-1:0];
  assign ser_rise = rise[2*NCH-1:NCH];
  assign txd_lvl  = lvl_q[3*NCH-1:2*NCH];
  assign rxd_lvl  = lvl_q[4*NCH-1:3*NCH];

  // ----------------------------------------------------------------
  // internal timing reference
  // ----------------------------------------------------------------
  logic [15:0] div_q, div_d;
  logic        int_tick, int_lvl;

  always_comb begin
    div_d = (div_q == 16'(INT_DIV - 1)) ? 16'h0000 : div_q + 16'h0001;
  end

  assign int_tick = (div_q == 16'h0000);
  assign int_lvl  = (div_q < 16'(INT_DIV / 2));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_d;
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [7:0] csr_q [NCH], csr_d [NCH];
  logic [7:0] line_interface_control_q [NCH], line_interface_control_d [NCH];
  logic [7:0] smr_q [NCH], smr_d [NCH];
  logic [7:0] bpc_q [NCH], bpc_d [NCH];
  logic [7:0] glob_q, glob_d;
  logic [NCH-1:0] ovr_q, ovr_d, ovr_set, ovr_clr;

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  logic                aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [ADDR_W-1:0]   awaddr_q, awaddr_d;
  logic [7:0]          wbyte_q, wbyte_d;
  logic                wlane_q, wlane_d;
  logic                bvalid_d, rvalid_d;
  logic [1:0]          bresp_d, rresp_d;
  logic [31:0]         rdata_d;
  logic                do_write, w_hit, r_hit;
  logic [15:0]         widx, ridx;
  logic [7:0]          rbyte;

  assign do_write = aw_held_q & w_held_q & ~bvalid;
  assign widx     = awaddr_q[ADDR_W-1:2];
  assign ridx     = araddr[ADDR_W-1:2];

  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d  = w_held_q;
    awaddr_d  = awaddr_q;
    wbyte_d   = wbyte_q;
    wlane_d   = wlane_q;
    bvalid_d  = bvalid;
    bresp_d   = bresp;
    w_hit     = 1'b0;
    glob_d    = glob_q;
    ovr_clr   = '0;
    if (awvalid && awready) begin
      aw_held_d = 1'b1;
      awaddr_d  = awaddr;
    end
    if (wvalid && wready) begin
      w_held_d = 1'b1;
      wbyte_d  = wdata[7:0];
      wlane_d  = wstrb[0];
    end
    for (int c = 0; c < NCH; c++) begin
      csr_d[c]  = csr_q[c];
      line_interface_control_d[c] = line_interface_control_q[c];
      smr_d[c]  = smr_q[c];
      bpc_d[c]  = bpc_q[c];
    end
    if (do_write) begin
      if (widx == IDX_LIU_GLOBAL0) begin
        w_hit = 1'b1;
        if (wlane_q) glob_d = wbyte_q & LIU_GLOBAL_MASK;
      end
      for (int c = 0; c < NCH; c++) begin
        if (widx[15:12] == 4'(c)) begin
          w_hit = w_hit | (widx[11:0] == IDX_CLOCK_SELECT) | (widx[11:0] == IDX_LINE_IF_CTRL)
                | (widx[11:0] == IDX_SYNC_MUX) | (widx[11:0] == IDX_BACKPLANE_CFG)
                | (widx[11:0] == IDX_CHAN_STATUS);
          if (wlane_q) begin
            case (widx[11:0])
              IDX_CLOCK_SELECT:  csr_d[c] = wbyte_q & CLOCK_SELECT_MASK;
              IDX_LINE_IF_CTRL: begin
                line_interface_control_d[c] = wbyte_q;
                // single rail only accepted with the global single-rail bit set
                line_interface_control_d[c][RAIL_MODE_BIT] = wbyte_q[RAIL_MODE_BIT] & glob_q[GLOBAL_SR_BIT];
              end
              IDX_SYNC_MUX:      smr_d[c] = wbyte_q & SYNC_MUX_MASK;
              IDX_BACKPLANE_CFG: bpc_d[c] = {7'h00, wbyte_q[HIGH_SPEED_BIT]};
              IDX_CHAN_STATUS:   ovr_clr[c] = wbyte_q[STAT_OVERRUN_BIT];
              default: ;
            endcase
          end
        end
      end
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = w_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && bready) begin
      bvalid_d = 1'b0;
    end
  end

  always_comb begin
    rvalid_d = rvalid;
    rdata_d  = rdata;
    rresp_d  = rresp;
    rbyte    = 8'h00;
    r_hit    = 1'b0;
    if (arvalid && arready) begin
      if (ridx == IDX_LIU_GLOBAL0) begin
        r_hit = 1'b1;
        rbyte = glob_q;
      end
      for (int c = 0; c < NCH; c++) begin
        if (ridx[15:12] == 4'(c)) begin
          r_hit = 1'b1;
          case (ridx[11:0])
            IDX_CLOCK_SELECT:  rbyte = csr_q[c];
            IDX_LINE_IF_CTRL:  rbyte = line_interface_control_q[c];
            IDX_SYNC_MUX:      rbyte = smr_q[c];
            IDX_BACKPLANE_CFG: rbyte = bpc_q[c];
            IDX_CHAN_STATUS:   rbyte = {2'h0, csr_q[c][CSS_LSB +: 2],
                                        1'b0, tx_frame_sync_pin_oe[c],
                                        tx_serial_clock_pin_oe[c], ovr_q[c]};
            default:           r_hit = 1'b0;
          endcase
        end
      end
      rvalid_d = 1'b1;
      rdata_d  = {24'h000000, rbyte};
      rresp_d  = r_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid_d = 1'b0;
    end
  end

  // the overrun flag: a new overrun wins over a clear in the same cycle
  assign ovr_d = (ovr_q & ~ovr_clr) | ovr_set;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awready   <= 1'b1;
      wready    <= 1'b1;
      arready   <= 1'b1;
      w_held_q  <= 1'b0;
      awaddr_q  <= '0;
      wbyte_q   <= 8'h00;
      wlane_q   <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
      rvalid    <= 1'b0;
      rdata     <= 32'h00000000;
      rresp     <= RESP_OKAY;
      glob_q    <= LIU_GLOBAL_RESET;
      ovr_q     <= '0;
      for (int c = 0; c < NCH; c++) begin
        csr_q[c]  <= CLOCK_SELECT_RESET;
        line_interface_control_q[c] <= LINE_IF_RESET;
        smr_q[c]  <= SYNC_MUX_RESET;
        bpc_q[c]  <= BACKPLANE_RESET;
      end
    end else begin
      aw_held_q <= aw_held_d;
      // ready outputs registered from the next holding and response state
      awready   <= ~aw_held_d & ~bvalid_d;
      wready    <= ~w_held_d & ~bvalid_d;
      arready   <= ~rvalid_d;
      w_held_q  <= w_held_d;
      awaddr_q  <= awaddr_d;
      wbyte_q   <= wbyte_d;
      wlane_q   <= wlane_d;
      bvalid    <= bvalid_d;
      bresp     <= bresp_d;
      rvalid    <= rvalid_d;
      rdata     <= rdata_d;
      rresp     <= rresp_d;
      glob_q    <= glob_d;
      ovr_q     <= ovr_d;
      for (int c = 0; c < NCH; c++) begin
        csr_q[c]  <= csr_d[c];
        line_interface_control_q[c] <= line_interface_control_d[c];
        smr_q[c]  <= smr_d[c];
        bpc_q[c]  <= bpc_d[c];
      end
    end
  end

  // ----------------------------------------------------------------
  // per-channel timing, pins and data path
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NCH; c++) begin : g_chan
    timing_source_type src;
    loopback_type      lb;
    logic              base_rate, tick, clk_lvl, txbit;
    logic [7:0]        bit_q, bit_d;
    logic [4:0]        frm_q, frm_d;
    logic              word_v_q, word_v_d, word_q, word_d, buf_ready, rxb_d;
    logic              ser_oe_d, syn_oe_d, ser_o_d;

    assign src       = timing_source_type'(csr_q[c][CSS_LSB +: 2]);
    assign lb        = loopback_type'(line_interface_control_q[c][LOOPBACK_LSB +: 2]);
    assign base_rate = ~bpc_q[c][HIGH_SPEED_BIT];

    always_comb begin
      case (src)
        CSS_EXTERNAL: begin
          tick    = ser_rise[c];
          clk_lvl = 1'b0;
        end
        CSS_INTERNAL: begin
          tick    = int_tick;
          clk_lvl = int_lvl;
        end
        default: begin
          tick    = rec_rise[c];
          clk_lvl = rec_lvl[c];
        end
      endcase
      // serial clock drives only in base rate and not in external timing
      ser_oe_d = base_rate & (src != CSS_EXTERNAL);
      ser_o_d  = ser_oe_d & clk_lvl;
      syn_oe_d = base_rate & smr_q[c][SYNC_INVERT_BIT];
      case (lb)
        LB_LOCAL:   txbit = 1'b1;
        LB_REMOTE:  txbit = rxd_lvl[c];
        LB_PAYLOAD: txbit = rxd_lvl[c];
        default:    txbit = txd_lvl[c];
      endcase
      if (line_interface_control_q[c][FORCE_LOSS_PATTERN_BIT]) txbit = 1'b0;
      rxb_d = rx_backplane_data[c];
      bit_d = bit_q;
      frm_d = frm_q;
      if (tick) begin
        rxb_d = (lb == LB_LOCAL) ? txd_lvl[c] : rxd_lvl[c];
        bit_d = (bit_q == 8'(FRAME_BITS - 1)) ? 8'h00 : bit_q + 8'h01;
        if (bit_q == 8'(FRAME_BITS - 1)) begin
          frm_d = (frm_q == 5'(MULTIFRAME_FRAMES - 1)) ? 5'h00 : frm_q + 5'h01;
        end
      end
      // the word stays offered until the buffer takes it or the next tick replaces it
      word_v_d = tick | (word_v_q & ~buf_ready);
      word_d   = tick ? txbit : word_q;
      ovr_set[c] = tick & word_v_q & ~buf_ready;
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        bit_q                        <= 8'h00;
        frm_q                        <= 5'h00;
        word_v_q                     <= 1'b0;
        word_q                       <= 1'b0;
        rx_backplane_data[c]         <= 1'b0;
        tx_serial_clock_pin_oe[c]    <= 1'b0;
        tx_serial_clock_pin_o[c]     <= 1'b0;
        tx_frame_sync_pin_oe[c]      <= 1'b0;
        tx_frame_sync_pin_o[c]       <= 1'b0;
        tx_multiframe_sync_pin_oe[c] <= 1'b0;
        tx_multiframe_sync_pin_o[c]  <= 1'b0;
      end else begin
        bit_q                        <= bit_d;
        frm_q                        <= frm_d;
        word_v_q                     <= word_v_d;
        word_q                       <= word_d;
        rx_backplane_data[c]         <= rxb_d;
        tx_serial_clock_pin_oe[c]    <= ser_oe_d;
        tx_serial_clock_pin_o[c]     <= ser_o_d;
        tx_frame_sync_pin_oe[c]      <= syn_oe_d;
        tx_frame_sync_pin_o[c]       <= syn_oe_d & (bit_q == 8'h00);
        tx_multiframe_sync_pin_oe[c] <= syn_oe_d;
        tx_multiframe_sync_pin_o[c]  <= syn_oe_d & (bit_q == 8'h00) & (frm_q == 5'h00);
      end
    end

    pair_buffer #(
      .WIDTH (1)
    ) u_line_buf (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .in_valid  (word_v_q),
      .in_ready  (buf_ready),
      .in_data   (word_q),
      .out_valid (line_tx_valid[c]),
      .out_ready (line_tx_ready[c]),
      .out_data  (line_tx_data[c])
    );
  end

endmodule : tx_timing_source_line_control
`default_nettype wire

/* tb/tx_timing_monitor.sv */
// checker of bus handshakes and pin relations of the timing control block
`timescale 1ns/10ps
`default_nettype none
module tx_timing_monitor
  import tx_timing_pkg::*;
#(
  parameter int unsigned NCH = 4
) (
  input wire logic           aclk,
  input wire logic           aresetn,
  input wire logic           awvalid,
  input wire logic           awready,
  input wire logic           wvalid,
  input wire logic           wready,
  input wire logic [1:0]     bresp,
  input wire logic           bvalid,
  input wire logic           bready,
  input wire logic           arvalid,
  input wire logic           arready,
  input wire logic [31:0]    rdata,
  input wire logic           rvalid,
  input wire logic           rready,
  input wire logic [NCH-1:0] tx_frame_sync_pin_o,
  input wire logic [NCH-1:0] tx_frame_sync_pin_oe,
  input wire logic [NCH-1:0] tx_multiframe_sync_pin_o,
  input wire logic [NCH-1:0] tx_multiframe_sync_pin_oe,
  input wire logic [NCH-1:0] line_tx_valid,
  input wire logic [NCH-1:0] line_tx_ready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_write_answer_due: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write response late");
  a_read_answer_due: assert property (arvalid && arready |=> rvalid)
    else $error("read response late");
  a_bresp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_rdata_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_busy_refuses: assert property (bvalid |-> !awready && !wready && (bresp == RESP_OKAY
    || bresp == RESP_SLVERR)) else $error("write taken while answering");
  a_read_refused: assert property (rvalid |-> !arready)
    else $error("read taken while answering");
  a_reset_clears: assert property (disable iff (1'b0)
    !aresetn |=> !bvalid && !rvalid && line_tx_valid == '0) else $error("reset left outputs");
  a_sync_dir_pair: assert property (tx_frame_sync_pin_oe == tx_multiframe_sync_pin_oe)
    else $error("sync pin directions differ");
  a_mframe_in_frame: assert property ((tx_multiframe_sync_pin_o & ~tx_frame_sync_pin_o) == '0)
    else $error("multiframe pulse outside frame pulse");
  a_line_word_holds: assert property ((line_tx_valid & ~line_tx_ready) != '0 |=>
    (line_tx_valid & $past(line_tx_valid & ~line_tx_ready)) == $past(line_tx_valid & ~line_tx_ready))
    else $error("line word withdrawn");
  c_write: cover property (bvalid && bready);
  c_read: cover property (rvalid && rready);
  c_line_stall: cover property ((line_tx_valid & ~line_tx_ready) != '0);
  c_sync_out: cover property (tx_frame_sync_pin_oe != '0);
endmodule : tx_timing_monitor
bind tx_timing_source_line_control tx_timing_monitor #(.NCH(NCH)) tx_timing_monitor_inst (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
  .tx_frame_sync_pin_o(tx_frame_sync_pin_o), .tx_frame_sync_pin_oe(tx_frame_sync_pin_oe),
  .tx_multiframe_sync_pin_o(tx_multiframe_sync_pin_o),
  .tx_multiframe_sync_pin_oe(tx_multiframe_sync_pin_oe),
  .line_tx_valid(line_tx_valid), .line_tx_ready(line_tx_ready));
`default_nettype wire

/* tb/link_far_end.sv */
// backplane clock source, recovered line clock and line receiver
`timescale 1ns/10ps
`default_nettype none
module link_far_end #(
  parameter int unsigned NCH = 4
) (
  input  wire logic           aclk,
  input  wire logic           stall,
  output logic      [NCH-1:0] ext_clk,
  output logic      [NCH-1:0] rec_clk,
  output logic      [NCH-1:0] ready
);
  // backplane clock runs free, 64 ns period
  initial begin
    ext_clk = '0;
    forever #32 ext_clk = ~ext_clk;
  end
  // recovered clock, unrelated phase
  initial begin
    rec_clk = '0;
    #13;
    forever #32 rec_clk = ~rec_clk;
  end
  // receiver takes every second cycle, or none while stalling
  initial begin
    ready = '0;
    forever @(posedge aclk) ready <= stall ? '0 : ~ready;
  end
endmodule : link_far_end
`default_nettype wire

/* tb/tb_tx_timing_source_line_control.sv */
// testbench of the timing source and line control block
`timescale 1ns/10ps
`default_nettype none
module tb_tx_timing_source_line_control;
  import tx_timing_pkg::*;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, stall, b;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb, ext_clk, rec_clk, sc_i, sc_o, sc_oe, fs_o, fs_oe, ms_o, ms_oe;
  logic [3:0]  tx_bp, rx_line, rx_bp, lt_valid, lt_ready, lt_data;
  logic [1:0]  bresp, rresp, r;
  int          bad_count, n_tests, cyc;
  // ----------------------------------------------------------------
  // design, far end and pin resolution
  // ----------------------------------------------------------------
  tx_timing_source_line_control #(.NCH(4), .INT_DIV(8)) tx_timing_source_line_control_inst (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .recovered_line_clock(rec_clk), .tx_serial_clock_pin_i(sc_i), .tx_serial_clock_pin_o(sc_o),
    .tx_serial_clock_pin_oe(sc_oe), .tx_frame_sync_pin_o(fs_o), .tx_frame_sync_pin_oe(fs_oe),
    .tx_multiframe_sync_pin_o(ms_o), .tx_multiframe_sync_pin_oe(ms_oe),
    .tx_backplane_data(tx_bp), .rx_line_data(rx_line), .rx_backplane_data(rx_bp),
    .line_tx_valid(lt_valid), .line_tx_ready(lt_ready), .line_tx_data(lt_data));
  link_far_end #(.NCH(4)) link_far_end_inst (
    .aclk(aclk), .stall(stall), .ext_clk(ext_clk), .rec_clk(rec_clk), .ready(lt_ready));
  assign sc_i = (sc_oe & sc_o) | (~sc_oe & ext_clk);
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  function automatic logic [15:0] ix(input int c, input logic [11:0] a);
    return {4'(c), a};
  endfunction : ix
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    awaddr <= {a, 2'b00};
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        tw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    chk(bresp, RESP_OKAY);
  endtask : wr
  task automatic rd(input logic [15:0] a);
    araddr <= {a, 2'b00};
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask : rd
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    rd(a);
    chk(d, {24'h0, e});
    chk(r, RESP_OKAY);
  endtask : rdc
  task automatic line_bit(input int c);
    repeat (40) @(posedge aclk);
    do @(posedge aclk); while (!(lt_valid[c] === 1'b1 && lt_ready[c] === 1'b1));
    b = lt_data[c];
  endtask : line_bit
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, arvalid, stall} = '0;
    {bready, rready} = 2'b11;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    tx_bp = 4'h0;
    rx_line = 4'hF;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(ix(0, IDX_CLOCK_SELECT), 8'h01);
    rdc(ix(0, IDX_LINE_IF_CTRL), 8'h00);
    rd(ix(0, 12'h102));
    chk(d, 32'h0);
    chk(r, RESP_SLVERR);
    for (int c = 0; c < 4; c++) wr(ix(c, IDX_CLOCK_SELECT), 8'(c * 5));
    repeat (3) @(posedge aclk);
    for (int c = 0; c < 4; c++) begin
      rdc(ix(c, IDX_CLOCK_SELECT), 8'(c * 5));
      chk(sc_oe[c], c != 1);
    end
    d = '0;
    repeat (8) begin
      @(posedge aclk);
      d[7:0] = d[7:0] | {sc_o, ~sc_o};
    end
    chk(d[7:0], 8'hDF);
    wr(ix(0, IDX_BACKPLANE_CFG), 8'h01);
    wr(ix(1, IDX_SYNC_MUX), 8'h10);
    repeat (3) @(posedge aclk);
    chk({sc_oe[0], fs_oe[0], fs_oe[1], ms_oe[1]}, 4'b0011);
    wr(ix(1, IDX_BACKPLANE_CFG), 8'h01);
    repeat (3) @(posedge aclk);
    chk({sc_oe[1], fs_oe[1], ms_oe[1]}, 3'b000);
    wr(ix(0, IDX_LINE_IF_CTRL), 8'h40);
    rdc(ix(0, IDX_LINE_IF_CTRL), 8'h00);
    wr(IDX_LIU_GLOBAL0, 8'h80);
    wr(ix(0, IDX_LINE_IF_CTRL), 8'h40);
    rdc(ix(0, IDX_LINE_IF_CTRL), 8'h40);
    for (int lb = 0; lb < 5; lb++) begin
      wr(ix(2, IDX_LINE_IF_CTRL), lb == 4 ? 8'hA0 : 8'(lb << 4));
      line_bit(2);
      chk(b, lb != 0 && lb != 4);
      chk(rx_bp[2], lb != 1);
    end
    wr(ix(2, IDX_LINE_IF_CTRL), 8'h00);
    stall <= 1'b1;
    repeat (60) @(posedge aclk);
    chk(lt_valid[2], 1'b1);
    rdc(ix(2, IDX_CHAN_STATUS), 8'h23);
    stall <= 1'b0;
    repeat (20) @(posedge aclk);
    wr(ix(2, IDX_CHAN_STATUS), 8'h01);
    rdc(ix(2, IDX_CHAN_STATUS), 8'h22);
    report_and_stop();
  end
endmodule : tb_tx_timing_source_line_control
`default_nettype wire
